// File: src/mac_tx_descriptor_dma.sv
// transmit buffer descriptor walker with axi4-lite control registers
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module mac_tx_descriptor_dma (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output txdma_pkg::mem_req_t mem_req,
  input wire txdma_pkg::mem_rsp_t mem_rsp,
  output txdma_pkg::tx_word_t tx_word,
  input wire logic tx_ready,
  input wire txdma_pkg::mac_ev_t mac_ev,
  input wire logic pause_active,
  output logic transmit_error_out
);
  import txdma_pkg::*;

  // ****************************************
  // types and state
  // ****************************************
  typedef enum {s_idle, s_desc0, s_desc1, s_data, s_push, s_wait, s_wback, s_err} st_t;
  st_t state;
  logic [31:0] qbase;
  logic [31:0] qptr;
  logic [31:0] fptr;
  logic [9:0] fcount;
  logic [9:0] count;
  logic tx_go;
  logic tx_en;
  logic pause_en;
  logic halt_pend;
  logic [31:0] buf_addr;
  logic [31:0] ctl_word;
  logic [31:0] first_ctl;
  logic [len_w-1:0] remain;
  logic in_frame;
  logic [7:0] nbuf;
  logic [31:0] fifo_word;
  logic [31:0] err_bits;
  logic [31:0] last_status;
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] strb_q;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_qptr;

  // next descriptor address, wrapping on bit or ring count
  function automatic logic [31:0] adv(input logic [31:0] p, input logic [31:0] c,
      input logic [9:0] n, input logic [31:0] base);
    if (c[d_wrap] || n == 10'(ring_max - 1)) begin
      adv = base;
    end else begin
      adv = p + desc_step;
    end
  endfunction

  function automatic logic [9:0] adv_n(input logic [31:0] c, input logic [9:0] n);
    if (c[d_wrap] || n == 10'(ring_max - 1)) begin
      adv_n = 10'h000;
    end else begin
      adv_n = n + 10'h001;
    end
  endfunction

  // ****************************************
  // axi4-lite write path
  // ****************************************
  assign wr_fire = aw_hold && w_hold && !s_bvalid;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      strb_q <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= resp_okay;
    end else begin
      s_awready <= !aw_hold && !s_awready;
      s_wready <= !w_hold && !s_wready;
      if (s_awvalid && s_awready) begin
        aw_hold <= 1'b1;
        aw_q <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_hold <= 1'b1;
        w_q <= s_wdata;
        strb_q <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= (aw_q == ctrl_addr || aw_q == qptr_addr || aw_q == cfg_addr
          || aw_q == stat_addr || aw_q == link_addr) ? resp_okay : resp_slverr;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  assign wr_ctrl = wr_fire && aw_q == ctrl_addr;
  assign wr_qptr = wr_fire && aw_q == qptr_addr && strb_q == 4'hF;

  // control and configuration bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_en <= 1'b0;
      pause_en <= 1'b0;
      qbase <= 32'h0000_0000;
    end else begin
      if (wr_ctrl && strb_q[0]) begin
        tx_en <= w_q[ctrl_tx_en];
      end
      if (wr_fire && aw_q == cfg_addr && strb_q[0]) begin
        pause_en <= w_q[cfg_pause_en];
      end
      if (wr_qptr) begin
        qbase <= {w_q[31:2], 2'b00};
      end
    end
  end

  // ****************************************
  // axi4-lite read path
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= resp_okay;
    end else begin
      s_arready <= !s_rvalid && !s_arready;
      if (s_arvalid && s_arready) begin
        s_arready <= 1'b0;
        s_rvalid <= 1'b1;
        s_rresp <= resp_okay;
        if (s_araddr == ctrl_addr) begin
          s_rdata <= 32'(tx_en) << ctrl_tx_en;
        end else if (s_araddr == qptr_addr) begin
          s_rdata <= qptr;
        end else if (s_araddr == stat_addr) begin
          s_rdata <= 32'(tx_go) << stat_go;
        end else if (s_araddr == cfg_addr) begin
          s_rdata <= 32'(pause_en) << cfg_pause_en;
        end else if (s_araddr == link_addr) begin
          s_rdata <= last_status;
        end else begin
          s_rdata <= 32'h0000_0000;
          s_rresp <= resp_slverr;
        end
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // transmit-go and halt
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_go <= 1'b0;
      halt_pend <= 1'b0;
    end else begin
      if (wr_ctrl && strb_q[1] && w_q[ctrl_halt]) begin
        halt_pend <= 1'b1;
      end
      if (wr_ctrl && strb_q[1] && w_q[ctrl_start]
          && (tx_en || (strb_q[0] && w_q[ctrl_tx_en]))) begin
        tx_go <= 1'b1;
        halt_pend <= 1'b0;
      end
      // halt only lands between frames
      if (halt_pend && !in_frame) begin
        tx_go <= 1'b0;
        halt_pend <= 1'b0;
      end
      // stop causes win over a same-cycle start
      if (wr_qptr || (wr_ctrl && strb_q[0] && !w_q[ctrl_tx_en])) begin
        tx_go <= 1'b0;
        halt_pend <= 1'b0;
      end
      if ((state == s_desc1 && mem_rsp.ack && mem_rsp.rdata[d_used]) || state == s_err) begin
        tx_go <= 1'b0;
      end
    end
  end

  // ****************************************
  // descriptor walker
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= s_idle;
      qptr <= 32'h0000_0000;
      fptr <= 32'h0000_0000;
      count <= 10'h000;
      fcount <= 10'h000;
      buf_addr <= 32'h0000_0000;
      ctl_word <= 32'h0000_0000;
      first_ctl <= 32'h0000_0000;
      remain <= '0;
      in_frame <= 1'b0;
      nbuf <= 8'h00;
      fifo_word <= 32'h0000_0000;
      err_bits <= 32'h0000_0000;
      last_status <= 32'h0000_0000;
      mem_req <= '0;
      tx_word <= '0;
      transmit_error_out <= 1'b0;
    end else begin
      transmit_error_out <= 1'b0;
      if (tx_word.valid && tx_ready) begin
        tx_word.valid <= 1'b0;
      end
      case (state)
        s_idle: begin
          // pause only holds off new frames
          if (tx_go && !halt_pend && !(pause_en && pause_active)) begin
            mem_req <= '{req: 1'b1, wr: 1'b0, addr: qptr, wdata: 32'h0000_0000};
            state <= s_desc0;
          end
          if (wr_qptr || (wr_ctrl && strb_q[0] && !w_q[ctrl_tx_en])) begin
            qptr <= wr_qptr ? {w_q[31:2], 2'b00} : qbase;
            count <= 10'h000;
            mem_req.req <= 1'b0;
            state <= s_idle;
          end
        end
        s_desc0: begin
          if (mem_rsp.ack) begin
            buf_addr <= mem_rsp.rdata;
            mem_req.addr <= qptr + word_step;
            state <= s_desc1;
          end
        end
        s_desc1: begin
          if (mem_rsp.ack) begin
            ctl_word <= mem_rsp.rdata;
            remain <= mem_rsp.rdata[len_w-1:0];
            if (mem_rsp.rdata[d_used]) begin
              mem_req.req <= 1'b0;
              if (in_frame) begin
                err_bits <= (32'h1 << d_exhaust) | (32'h1 << d_under);
                state <= s_err;
              end else begin
                state <= s_idle;
              end
            end else begin
              if (!in_frame) begin
                first_ctl <= mem_rsp.rdata;
                fptr <= qptr;
                fcount <= count;
              end
              in_frame <= 1'b1;
              nbuf <= (in_frame ? nbuf : 8'h00) + 8'h01;
              mem_req.addr <= mem_rsp.rdata[len_w-1:0] == '0 ? mem_req.addr : buf_addr;
              mem_req.req <= mem_rsp.rdata[len_w-1:0] != '0;
              state <= mem_rsp.rdata[len_w-1:0] != '0 ? s_data : s_push;
            end
          end
        end
        s_data: begin
          if (mem_rsp.ack) begin
            mem_req.req <= 1'b0;
            fifo_word <= mem_rsp.rdata;
            if (mem_rsp.err) begin
              err_bits <= 32'h1 << d_under;
              state <= s_err;
            end else begin
              state <= s_push;
            end
          end
        end
        s_push: begin
          if (!tx_word.valid || tx_ready) begin
            if (remain == '0) begin
              qptr <= adv(qptr, ctl_word, count, qbase);
              count <= adv_n(ctl_word, count);
              if (ctl_word[d_last] || nbuf == 8'(max_bufs)) begin
                // zero-length last buffer still closes the frame
                tx_word <= '{valid: 1'b1, last: 1'b1, nbytes: 2'h0, data: 32'h0};
                state <= s_wait;
              end else begin
                mem_req <= '{req: 1'b1, wr: 1'b0, addr: adv(qptr, ctl_word, count, qbase),
                  wdata: 32'h0000_0000};
                state <= s_desc0;
              end
            end else begin
              tx_word <= '{valid: 1'b1, last: 1'b0, nbytes: remain > 11'd4 ? 2'h0 : remain[1:0],
                data: fifo_word};
              remain <= remain > 11'd4 ? remain - 11'd4 : '0;
              buf_addr <= buf_addr + word_step;
              if (remain > 11'd4) begin
                mem_req <= '{req: 1'b1, wr: 1'b0, addr: buf_addr + word_step,
                  wdata: 32'h0000_0000};
                state <= s_data;
              end
            end
          end
        end
        s_wait: begin
          // mac pads to 64 bytes unless no-crc is in the last buffer
          if (mac_ev.collision) begin
            qptr <= fptr;
            count <= fcount;
            in_frame <= 1'b0;
            mem_req <= '{req: 1'b1, wr: 1'b0, addr: fptr, wdata: 32'h0000_0000};
            state <= s_desc0;
          end else if (mac_ev.retry_limit || mac_ev.late) begin
            err_bits <= mac_ev.retry_limit ? 32'h1 << d_retry : 32'h1 << d_under;
            state <= s_err;
          end else if (mac_ev.done) begin
            mem_req <= '{req: 1'b1, wr: 1'b1, addr: fptr + word_step,
              wdata: first_ctl | (32'h1 << d_used)};
            last_status <= first_ctl | (32'h1 << d_used);
            state <= s_wback;
          end
        end
        s_wback: begin
          if (mem_rsp.ack) begin
            mem_req.req <= 1'b0;
            in_frame <= 1'b0;
            state <= s_idle;
          end
        end
        s_err: begin
          // bad fcs forced by the mac while strobed; a stalled word drains first
          if (!tx_word.valid || tx_ready) begin
            transmit_error_out <= 1'b1;
            tx_word <= '{valid: 1'b1, last: 1'b1, nbytes: 2'h0, data: 32'h0};
            last_status <= first_ctl | err_bits | (32'h1 << d_used);
            qptr <= qbase;
            count <= 10'h000;
            in_frame <= 1'b0;
            mem_req <= '{req: 1'b1, wr: 1'b1, addr: fptr + word_step,
              wdata: first_ctl | err_bits | (32'h1 << d_used)};
            state <= s_wback;
          end
        end
        default: begin
          state <= s_idle;
        end
      endcase
    end
  end
  // pad to min_frame and no-crc are left to the mac at the end token
endmodule // mac_tx_descriptor_dma

// File: src/txdma_pkg.sv
// shared constants and types for the transmit descriptor dma
package txdma_pkg;
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] qptr_addr = 8'h04;
  localparam logic [7:0] stat_addr = 8'h08;
  localparam logic [7:0] cfg_addr = 8'h0C;
  localparam logic [7:0] link_addr = 8'h10;
  localparam int ctrl_tx_en = 3;
  localparam int ctrl_start = 9;
  localparam int ctrl_halt = 10;
  localparam int stat_go = 3;
  localparam int cfg_pause_en = 0;
  localparam int d_used = 31;
  localparam int d_wrap = 30;
  localparam int d_retry = 29;
  localparam int d_under = 28;
  localparam int d_exhaust = 27;
  localparam int d_nocrc = 16;
  localparam int d_last = 15;
  localparam int len_w = 11;
  localparam int max_bufs = 128;
  localparam int ring_max = 1024;
  localparam int min_frame = 64;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  localparam logic [31:0] desc_step = 32'h0000_0008;
  localparam logic [31:0] word_step = 32'h0000_0004;
  typedef struct packed {
    logic req;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } mem_rsp_t;
  typedef struct packed {
    logic valid;
    logic last;
    logic [1:0] nbytes;
    logic [31:0] data;
  } tx_word_t;
  typedef struct packed {
    logic done;
    logic collision;
    logic retry_limit;
    logic late;
  } mac_ev_t;
endpackage

// File: bench/txdma_properties.sv
// port assertions for the transmit descriptor dma
`timescale 1ns/10ps
module txdma_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic [1:0] s_rresp,
  input wire logic s_rvalid,
  input wire txdma_pkg::mem_req_t mem_req,
  input wire txdma_pkg::mem_rsp_t mem_rsp,
  input wire txdma_pkg::tx_word_t tx_word,
  input wire logic tx_ready,
  input wire logic transmit_error_out
);
  import txdma_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence req_wait;
    mem_req.req && !mem_rsp.ack;
  endsequence
  sequence req_same;
    mem_req.req && $stable(mem_req.addr) && $stable(mem_req.wr);
  endsequence
  chk_req_held: assert property (req_wait |=> req_same)
    else $error("memory request changed before ack");
  chk_wb_used: assert property (mem_req.req && mem_req.wr |-> mem_req.wdata[d_used])
    else $error("status write without used bit");
  chk_word_held: assert property (tx_word.valid && !tx_ready |=> $stable(tx_word))
    else $error("transmit word dropped while stalled");
  chk_token_zero: assert property (tx_word.valid && tx_word.last |-> tx_word.data == 32'h0)
    else $error("end token carries data");
  chk_err_pulse: assert property (transmit_error_out |=> !transmit_error_out)
    else $error("error output longer than a pulse");
  chk_rd_unmapped: assert property (s_arvalid && s_arready && s_araddr > link_addr
    |=> s_rvalid && s_rresp == resp_slverr && s_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_aw_busy: assert property (s_awvalid && s_awready && s_wvalid && s_wready |=> !s_awready)
    else $error("write ready stayed high while busy");
  chk_ar_busy: assert property (s_arvalid && s_arready |=> !s_arready)
    else $error("read ready stayed high while busy");
endmodule // txdma_checker
bind mac_tx_descriptor_dma txdma_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
  .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
  .s_rresp(s_rresp), .s_rvalid(s_rvalid), .mem_req(mem_req), .mem_rsp(mem_rsp),
  .tx_word(tx_word), .tx_ready(tx_ready), .transmit_error_out(transmit_error_out));

// File: bench/txdma_mem_model.sv
// system memory answering the dma master port
`timescale 1ns/10ps
module txdma_mem_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire txdma_pkg::mem_req_t mem_req,
  output txdma_pkg::mem_rsp_t mem_rsp,
  input wire logic [3:0] lat
);
  import txdma_pkg::*;
  logic [31:0] mem [0:255];
  logic [3:0] cnt;
  // ack only after lat idle cycles, so slow memory is exercised too
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rsp <= '0;
      cnt <= 4'h0;
    end else if (mem_rsp.ack) begin
      mem_rsp.ack <= 1'b0;
      mem_rsp.rdata <= ~mem_rsp.rdata; // released bus never holds old data
    end else if (mem_req.req && cnt == lat) begin
      mem_rsp.ack <= 1'b1;
      cnt <= 4'h0;
      if (mem_req.wr) begin
        mem[mem_req.addr[9:2]] <= mem_req.wdata;
      end else begin
        mem_rsp.rdata <= mem[mem_req.addr[9:2]];
      end
    end else begin
      cnt <= mem_req.req ? cnt + 4'h1 : 4'h0;
      mem_rsp.rdata <= ~mem_rsp.rdata;
    end
  end
endmodule // txdma_mem_model

// File: bench/mac_tx_descriptor_dma_test.sv
// self-checking bench for the transmit descriptor dma
`timescale 1ns/10ps
module mac_tx_descriptor_dma_test;
  import txdma_pkg::*;
  localparam logic [31:0] qbase = 32'h0000_0100;
  localparam logic [31:0] go_cmd = 32'h0000_0208;
  localparam logic [31:0] b0 = 32'h1111_AAAA;
  localparam logic [31:0] b1 = 32'h2222_BBBB;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata, rd;
  logic [3:0] s_wstrb = 4'hF, lat = 4'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, transmit_error_out;
  logic [1:0] s_bresp, s_rresp, rr;
  logic tx_ready = 1'b1, pause_active = 1'b0, slow = 1'b0, coll = 1'b0, rlim = 1'b0, eof;
  mem_req_t mem_req;
  mem_rsp_t mem_rsp;
  tx_word_t tx_word;
  mac_ev_t mac_ev = '0;
  logic [31:0] words [$];
  int frames, errs, cyc, checks, fail_count;
  always #5 ref_clk = ~ref_clk;
  mac_tx_descriptor_dma DUT (.ref_clk(ref_clk), .rst_n(rst_n), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .mem_req(mem_req), .mem_rsp(mem_rsp), .tx_word(tx_word), .tx_ready(tx_ready),
    .mac_ev(mac_ev), .pause_active(pause_active), .transmit_error_out(transmit_error_out));
  txdma_mem_model u_mem (.ref_clk(ref_clk), .rst_n(rst_n), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .lat(lat));
  // ****************
  // mac side and timeout
  // ****************
  always @(posedge ref_clk) begin
    cyc++;
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (transmit_error_out) errs++;
    if (tx_word.valid && tx_ready && !tx_word.last) words.push_back(tx_word.data);
    eof = tx_word.valid && tx_ready && tx_word.last;
    // one outcome per end token
    mac_ev <= '{done: eof && !coll && !rlim, collision: eof && coll, retry_limit: eof && rlim,
      late: 1'b0};
    if (eof) begin
      frames++;
      coll <= 1'b0;
      rlim <= 1'b0;
    end
    if (cyc == 30000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // ****************
  // register bus and helpers
  // ****************
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    fork
      begin
        do @(posedge ref_clk); while (!s_awready);
        s_awvalid <= 1'b0;
      end
      begin
        do @(posedge ref_clk); while (!s_wready);
        s_wvalid <= 1'b0;
      end
    join
    while (!s_bvalid) @(posedge ref_clk);
    rr = s_bresp;
    s_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge ref_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_arready);
    s_arvalid <= 1'b0;
    while (!s_rvalid) @(posedge ref_clk);
    rd = s_rdata;
    rr = s_rresp;
    s_rready <= 1'b0;
  endtask
  task automatic wait_frames(input int n);
    repeat (3000) if (frames < n) @(posedge ref_clk);
  endtask
  task automatic wait_idle();
    repeat (200) begin
      axr(stat_addr);
      if (rd[stat_go] === 1'b0) break;
    end
    // on an error, go drops before the status write-back lands
    repeat (8) @(posedge ref_clk);
  endtask
  // three descriptors: two under test, a third that only a missed wrap reaches
  task automatic setq(input logic [31:0] c0, input logic [31:0] c1);
    u_mem.mem[64] = 32'h0000_0200;
    u_mem.mem[65] = c0;
    u_mem.mem[66] = 32'h0000_0204;
    u_mem.mem[67] = c1;
    u_mem.mem[68] = 32'h0000_0208;
    u_mem.mem[69] = 32'h4000_8004;
    words.delete();
    frames = 0;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs();
    axr(stat_addr);
    chk(rd[stat_go], 1'b0);
    axr(8'h20);
    chk(rd, 32'h0);
    chk(rr, resp_slverr);
    axw(8'h20, 32'h0);
    chk(rr, resp_slverr);
    $display("register test done");
  endtask
  task automatic t_frame();
    setq(32'h0000_0004, 32'h4000_8004);
    coll = 1'b1;
    axw(qptr_addr, qbase);
    chk(rr, resp_okay);
    axw(ctrl_addr, go_cmd);
    axw(ctrl_addr, go_cmd);
    wait_frames(2);
    wait_idle();
    chk(words.size(), 4);
    chk(words[0], b0);
    chk(words[2], b0);
    chk(words[3], b1);
    chk(u_mem.mem[65][d_used], 1'b1);
    chk(u_mem.mem[67][d_used], 1'b0);
    chk(rd[stat_go], 1'b0);
    $display("frame test done");
  endtask
  task automatic t_resume();
    u_mem.mem[65] = 32'h0000_8004;
    u_mem.mem[67] = 32'hC000_8004;
    words.delete();
    frames = 0;
    axw(ctrl_addr, go_cmd);
    wait_frames(1);
    wait_idle();
    axr(qptr_addr);
    chk(rd, qbase + desc_step);
    u_mem.mem[67] = 32'h4000_8004;
    axw(ctrl_addr, go_cmd);
    wait_frames(2);
    wait_idle();
    chk(words.size(), 2);
    chk(words[1], b1);
    chk(frames, 2);
    $display("resume test done");
  endtask
  task automatic t_mid();
    setq(32'h0000_0004, 32'h8000_8004);
    errs = 0;
    lat = 4'h1;
    axw(qptr_addr, qbase);
    axw(ctrl_addr, go_cmd);
    wait_idle();
    chk(errs, 1);
    chk(u_mem.mem[65][d_exhaust], 1'b1);
    chk(u_mem.mem[65][d_used], 1'b1);
    axr(link_addr);
    chk(rd, 32'h9800_0004);
    u_mem.mem[65] = 32'h0000_8004;
    words.delete();
    axw(ctrl_addr, go_cmd);
    wait_idle();
    chk(words[0], b0);
    u_mem.mem[65] = 32'h0000_8004;
    rlim = 1'b1;
    axw(qptr_addr, qbase);
    axw(ctrl_addr, go_cmd);
    wait_idle();
    chk(u_mem.mem[65], 32'hA000_8004);
    chk(errs, 2);
    $display("midframe test done");
  endtask
  task automatic t_pause();
    setq(32'h4000_8004, 32'h0000_8004);
    axw(cfg_addr, 32'h0000_0001);
    pause_active <= 1'b1;
    axw(qptr_addr, qbase);
    axw(ctrl_addr, go_cmd);
    repeat (50) @(posedge ref_clk);
    chk(frames, 0);
    pause_active <= 1'b0;
    wait_frames(1);
    wait_idle();
    chk(frames, 1);
    $display("pause test done");
  endtask
  task automatic t_halt();
    setq(32'h0000_8008, 32'h4000_8004);
    slow = 1'b1;
    lat = 4'h3;
    axw(ctrl_addr, go_cmd);
    repeat (3000) if (words.size() == 0) @(posedge ref_clk);
    axw(ctrl_addr, 32'h0000_0408); // halt, enable kept
    wait_idle();
    repeat (100) @(posedge ref_clk);
    chk(frames, 1);
    axw(ctrl_addr, 32'h0);
    u_mem.mem[65] = 32'h0000_8008;
    words.delete();
    axw(ctrl_addr, 32'h0000_0008);
    axw(ctrl_addr, go_cmd);
    wait_idle();
    chk(words[0], b0);
    slow = 1'b0;
    $display("halt test done");
  endtask
  initial begin
    u_mem.mem[128] = b0;
    u_mem.mem[129] = b1;
    u_mem.mem[130] = 32'h3333_CCCC;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_regs();
    t_frame();
    t_resume();
    t_mid();
    t_pause();
    t_halt();
    give_verdict();
  end
endmodule // mac_tx_descriptor_dma_test
